// ==== hw/gpio_pkg.sv ====
`default_nettype none
// ==========================================================================
// Shared constants for the general-purpose port block.
package gpio_pkg;

  // ========================================================================
  // Widths and counts.
  localparam int PORT_W     = 8;
  localparam int NUM_BANKS  = 4;
  localparam int IDX_W      = 6;
  localparam int DATA_W     = 32;
  localparam int EXT_ADDR_W = 16;
  localparam int BANK_A     = 0;
  localparam int BANK_B     = 1;
  localparam int BANK_C     = 2;
  localparam int BANK_D     = 3;

  // ========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] BANK_A_OUT_IDX = 6'h1B;
  localparam logic [IDX_W-1:0] BANK_A_DIR_IDX = 6'h1A;
  localparam logic [IDX_W-1:0] BANK_A_PIN_IDX = 6'h19;
  localparam logic [IDX_W-1:0] BANK_B_OUT_IDX = 6'h18;
  localparam logic [IDX_W-1:0] BANK_B_DIR_IDX = 6'h17;
  localparam logic [IDX_W-1:0] BANK_B_PIN_IDX = 6'h16;
  localparam logic [IDX_W-1:0] BANK_C_OUT_IDX = 6'h15;
  localparam logic [IDX_W-1:0] BANK_C_DIR_IDX = 6'h14;
  localparam logic [IDX_W-1:0] BANK_C_PIN_IDX = 6'h13;
  localparam logic [IDX_W-1:0] BANK_D_OUT_IDX = 6'h12;
  localparam logic [IDX_W-1:0] BANK_D_DIR_IDX = 6'h11;
  localparam logic [IDX_W-1:0] BANK_D_PIN_IDX = 6'h10;
  localparam logic [IDX_W-1:0] EXT_CTRL_IDX   = 6'h20;
  localparam logic [IDX_W-1:0] EXT_ADDR_IDX   = 6'h21;
  localparam logic [IDX_W-1:0] EXT_DATA_IDX   = 6'h22;
  localparam logic [IDX_W-1:0] EXT_CMD_IDX    = 6'h23;

  localparam logic [IDX_W-1:0] OUT_IDX [NUM_BANKS] = '{BANK_A_OUT_IDX, BANK_B_OUT_IDX,
                                                      BANK_C_OUT_IDX, BANK_D_OUT_IDX};
  localparam logic [IDX_W-1:0] DIR_IDX [NUM_BANKS] = '{BANK_A_DIR_IDX, BANK_B_DIR_IDX,
                                                      BANK_C_DIR_IDX, BANK_D_DIR_IDX};
  localparam logic [IDX_W-1:0] PIN_IDX [NUM_BANKS] = '{BANK_A_PIN_IDX, BANK_B_PIN_IDX,
                                                      BANK_C_PIN_IDX, BANK_D_PIN_IDX};

  // ========================================================================
  // Field positions and reset values.
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CMD_RD_BIT    = 0;
  localparam int CMD_WR_BIT    = 1;
  localparam logic [PORT_W-1:0]     LATCH_RST    = 8'h00;
  localparam logic [PORT_W-1:0]     DIR_RST      = 8'h00;
  localparam logic [EXT_ADDR_W-1:0] EXT_ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0]     DATA_ZERO    = 32'h0000_0000;

  // ========================================================================
  // Timing: least reset pulse, rounded up to whole clock cycles.
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_MIN_NS  = 50;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // External memory access phases.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_DATA = 2'b10,
    SEQ_DONE = 2'b11
  } seq_state_t;

  // Tells whether a bus index selects a given register.
  function automatic logic reg_hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] reg_idx);
    return idx == reg_idx;
  endfunction

endpackage
`default_nettype wire

// ==== hw/gpio_bank.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// One 8-line port: output latch, direction and pad drivers.
module gpio_bank
  import gpio_pkg::*;
#(
  parameter int WIDTH = PORT_W
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             wr_out_i,
  input  wire logic             wr_dir_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             ovr_en_i,
  input  wire logic [WIDTH-1:0] ovr_out_i,
  input  wire logic [WIDTH-1:0] ovr_oe_i,
  output logic      [WIDTH-1:0] latch_o,
  output logic      [WIDTH-1:0] dir_o,
  output logic      [WIDTH-1:0] pad_out_o,
  output logic      [WIDTH-1:0] pad_oe_o,
  output logic      [WIDTH-1:0] pad_pu_o
);

  logic [WIDTH-1:0] latch_nxt;
  logic [WIDTH-1:0] dir_nxt;
  logic [WIDTH-1:0] out_nxt;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] pu_nxt;

  // Register writes and the pad values that follow from them.
  always_comb begin
    latch_nxt = wr_out_i ? wdata_i : latch_o;
    dir_nxt   = wr_dir_i ? wdata_i : dir_o;
    if (ovr_en_i) begin
      out_nxt = ovr_out_i;
      oe_nxt  = ovr_oe_i;
      pu_nxt  = '0;
    end else begin
      out_nxt = latch_o;
      oe_nxt  = dir_o;
      pu_nxt  = ~dir_o & latch_o;
    end
  end

  // Software state, cleared with the clock.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latch_o <= LATCH_RST;
      dir_o   <= DIR_RST;
    end else begin
      latch_o <= latch_nxt;
      dir_o   <= dir_nxt;
    end
  end

  // Pad drivers float the moment reset falls, with or without a clock.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_out_o <= '0;
      pad_oe_o  <= '0;
      pad_pu_o  <= '0;
    end else begin
      pad_out_o <= out_nxt;
      pad_oe_o  <= oe_nxt;
      pad_pu_o  <= pu_nxt;
    end
  end

endmodule // gpio_bank
`default_nettype wire

// ==== hw/ext_bus_seq.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Two-phase external memory access on the multiplexed lines.
module ext_bus_seq
  import gpio_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  start_rd_i,
  input  wire logic                  start_wr_i,
  input  wire logic [EXT_ADDR_W-1:0] addr_i,
  input  wire logic [PORT_W-1:0]     wdata_i,
  input  wire logic [PORT_W-1:0]     ad_i,
  output logic                       busy_o,
  output logic      [PORT_W-1:0]     ad_out_o,
  output logic                       ad_oe_o,
  output logic                       ale_o,
  output logic                       wr_n_o,
  output logic                       rd_n_o,
  output logic      [PORT_W-1:0]     rdata_o
);

  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic              is_wr_r;
  logic              is_wr_nxt;
  logic [PORT_W-1:0] ad_out_nxt;
  logic              ad_oe_nxt;
  logic              ale_nxt;
  logic              wr_n_nxt;
  logic              rd_n_nxt;
  logic [PORT_W-1:0] rdata_nxt;

  // Phase outputs are set on entry to each state; the pad stage adds one cycle.
  always_comb begin
    state_nxt  = state_r;
    is_wr_nxt  = is_wr_r;
    ad_out_nxt = ad_out_o;
    ad_oe_nxt  = 1'b0;
    ale_nxt    = 1'b0;
    wr_n_nxt   = 1'b1;
    rd_n_nxt   = 1'b1;
    rdata_nxt  = rdata_o;
    case (state_r)
      SEQ_IDLE: begin
        if (start_rd_i || start_wr_i) begin
          state_nxt  = SEQ_ADDR;
          is_wr_nxt  = start_wr_i;
          ale_nxt    = 1'b1;
          ad_oe_nxt  = 1'b1;
          ad_out_nxt = addr_i[PORT_W-1:0];
        end
      end
      SEQ_ADDR: begin
        state_nxt = SEQ_DATA;
        if (is_wr_r) begin
          ad_oe_nxt  = 1'b1;
          ad_out_nxt = wdata_i;
          wr_n_nxt   = 1'b0;
        end else begin
          rd_n_nxt = 1'b0;
        end
      end
      SEQ_DATA: begin
        state_nxt = SEQ_DONE;
      end
      SEQ_DONE: begin
        state_nxt = SEQ_IDLE;
        if (!is_wr_r) begin
          rdata_nxt = ad_i;
        end
      end
      default: begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  // State and phase registers.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r  <= SEQ_IDLE;
      is_wr_r  <= 1'b0;
      ad_out_o <= '0;
      ad_oe_o  <= 1'b0;
      ale_o    <= 1'b0;
      wr_n_o   <= 1'b1;
      rd_n_o   <= 1'b1;
      rdata_o  <= '0;
    end else begin
      state_r  <= state_nxt;
      is_wr_r  <= is_wr_nxt;
      ad_out_o <= ad_out_nxt;
      ad_oe_o  <= ad_oe_nxt;
      ale_o    <= ale_nxt;
      wr_n_o   <= wr_n_nxt;
      rd_n_o   <= rd_n_nxt;
      rdata_o  <= rdata_nxt;
    end
  end

  assign busy_o = (state_r != SEQ_IDLE);

endmodule // ext_bus_seq
`default_nettype wire

// ==== hw/parallel_io_ports.sv ====
// Behaviour
// - Every port has eight individually bidirectional lines, each with a pull-up.
// - An input line enables its pull-up only when that pull-up is activated.
// - Any reset floats all port lines at once, asynchronously, even without clock.
// - A low reset longer than 50 ns resets the block without a clock; here only pads and strobes do, other registers reset on a clock edge.
// - With external memory enabled, the third port drives high address bits.
// - First access cycle puts low address out with latch strobe; second carries data.
// - Each port has output latch, direction and read-only pin registers, descending.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Four general-purpose ports with a classic Wishbone register slave.
module parallel_io_ports
  import gpio_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Wishbone slave.
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  // Port lines: pin level, drive value, drive enable, pull-up enable.
  input  wire logic [PORT_W-1:0] bank_a_lines_i,
  output wire logic [PORT_W-1:0] bank_a_lines_o,
  output wire logic [PORT_W-1:0] bank_a_lines_oe_o,
  output wire logic [PORT_W-1:0] bank_a_lines_pu_o,
  input  wire logic [PORT_W-1:0] bank_b_lines_i,
  output wire logic [PORT_W-1:0] bank_b_lines_o,
  output wire logic [PORT_W-1:0] bank_b_lines_oe_o,
  output wire logic [PORT_W-1:0] bank_b_lines_pu_o,
  input  wire logic [PORT_W-1:0] bank_c_lines_i,
  output wire logic [PORT_W-1:0] bank_c_lines_o,
  output wire logic [PORT_W-1:0] bank_c_lines_oe_o,
  output wire logic [PORT_W-1:0] bank_c_lines_pu_o,
  input  wire logic [PORT_W-1:0] bank_d_lines_i,
  output wire logic [PORT_W-1:0] bank_d_lines_o,
  output wire logic [PORT_W-1:0] bank_d_lines_oe_o,
  output wire logic [PORT_W-1:0] bank_d_lines_pu_o,
  // External memory strobes.
  output logic                   ale_o,
  output logic                   wr_n_o,
  output logic                   rd_n_o
);

  // ========================================================================
  // Declarations.
  logic [PORT_W-1:0]     pin_w     [NUM_BANKS];
  logic [PORT_W-1:0]     latch_w   [NUM_BANKS];
  logic [PORT_W-1:0]     dir_w     [NUM_BANKS];
  logic [PORT_W-1:0]     pad_out_w [NUM_BANKS];
  logic [PORT_W-1:0]     pad_oe_w  [NUM_BANKS];
  logic [PORT_W-1:0]     pad_pu_w  [NUM_BANKS];
  logic [NUM_BANKS-1:0]  wr_out_w;
  logic [NUM_BANKS-1:0]  wr_dir_w;
  logic [NUM_BANKS-1:0]  ovr_en_w;
  logic [PORT_W-1:0]     ovr_out_w [NUM_BANKS];
  logic [PORT_W-1:0]     ovr_oe_w  [NUM_BANKS];
  logic [IDX_W-1:0]      idx_w;
  logic                  req_w;
  logic                  wr_req_w;
  logic                  ack_nxt;
  logic [DATA_W-1:0]     dat_nxt;
  logic                  ext_en_r;
  logic                  ext_en_nxt;
  logic [EXT_ADDR_W-1:0] ext_addr_r;
  logic [EXT_ADDR_W-1:0] ext_addr_nxt;
  logic [PORT_W-1:0]     ext_wdata_r;
  logic [PORT_W-1:0]     ext_wdata_nxt;
  logic                  start_rd_w;
  logic                  start_wr_w;
  logic                  seq_busy_w;
  logic [PORT_W-1:0]     seq_ad_out_w;
  logic                  seq_ad_oe_w;
  logic                  seq_ale_w;
  logic                  seq_wr_n_w;
  logic                  seq_rd_n_w;
  logic [PORT_W-1:0]     seq_rdata_w;

  // Pin levels gathered by bank number.
  assign pin_w[BANK_A] = bank_a_lines_i;
  assign pin_w[BANK_B] = bank_b_lines_i;
  assign pin_w[BANK_C] = bank_c_lines_i;
  assign pin_w[BANK_D] = bank_d_lines_i;

  // ========================================================================
  // Bus request qualification; each request is taken once, then acked.
  assign idx_w    = adr_i[7:2];
  assign req_w    = cyc_i && stb_i && !ack_o;
  assign wr_req_w = req_w && we_i;

  // Register decode for writes and reads.
  always_comb begin
    ack_nxt       = req_w;
    dat_nxt       = dat_o;
    ext_en_nxt    = ext_en_r;
    ext_addr_nxt  = ext_addr_r;
    ext_wdata_nxt = ext_wdata_r;
    start_rd_w    = 1'b0;
    start_wr_w    = 1'b0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      wr_out_w[b] = wr_req_w && sel_i[0] && reg_hit(idx_w, OUT_IDX[b]);
      wr_dir_w[b] = wr_req_w && sel_i[0] && reg_hit(idx_w, DIR_IDX[b]);
    end
    if (wr_req_w) begin
      if (reg_hit(idx_w, EXT_CTRL_IDX) && sel_i[0]) begin
        ext_en_nxt = dat_i[CTRL_EN_BIT];
      end else if (reg_hit(idx_w, EXT_ADDR_IDX)) begin
        if (sel_i[0]) ext_addr_nxt[7:0]  = dat_i[7:0];
        if (sel_i[1]) ext_addr_nxt[15:8] = dat_i[15:8];
      end else if (reg_hit(idx_w, EXT_DATA_IDX) && sel_i[0]) begin
        ext_wdata_nxt = dat_i[PORT_W-1:0];
      end else if (reg_hit(idx_w, EXT_CMD_IDX) && sel_i[0] && ext_en_r && !seq_busy_w) begin
        start_rd_w = dat_i[CMD_RD_BIT] && !dat_i[CMD_WR_BIT];
        start_wr_w = dat_i[CMD_WR_BIT];
      end
    end
    if (req_w && !we_i) begin
      dat_nxt = DATA_ZERO;
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (reg_hit(idx_w, OUT_IDX[b])) begin
          dat_nxt[PORT_W-1:0] = latch_w[b];
        end else if (reg_hit(idx_w, DIR_IDX[b])) begin
          dat_nxt[PORT_W-1:0] = dir_w[b];
        end else if (reg_hit(idx_w, PIN_IDX[b])) begin
          dat_nxt[PORT_W-1:0] = pin_w[b];
        end
      end
      if (reg_hit(idx_w, EXT_CTRL_IDX)) begin
        dat_nxt[CTRL_EN_BIT]   = ext_en_r;
        dat_nxt[CTRL_BUSY_BIT] = seq_busy_w;
      end else if (reg_hit(idx_w, EXT_ADDR_IDX)) begin
        dat_nxt[EXT_ADDR_W-1:0] = ext_addr_r;
      end else if (reg_hit(idx_w, EXT_DATA_IDX)) begin
        dat_nxt[PORT_W-1:0] = seq_rdata_w;
      end
    end
  end

  // Bus answer and external access settings.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_o       <= 1'b0;
      dat_o       <= DATA_ZERO;
      ext_en_r    <= 1'b0;
      ext_addr_r  <= EXT_ADDR_RST;
      ext_wdata_r <= LATCH_RST;
    end else begin
      ack_o       <= ack_nxt;
      dat_o       <= dat_nxt;
      ext_en_r    <= ext_en_nxt;
      ext_addr_r  <= ext_addr_nxt;
      ext_wdata_r <= ext_wdata_nxt;
    end
  end

  // ========================================================================
  // External memory sequencer.
  ext_bus_seq u_seq (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .start_rd_i (start_rd_w),
    .start_wr_i (start_wr_w),
    .addr_i     (ext_addr_r),
    .wdata_i    (ext_wdata_r),
    .ad_i       (bank_a_lines_i),
    .busy_o     (seq_busy_w),
    .ad_out_o   (seq_ad_out_w),
    .ad_oe_o    (seq_ad_oe_w),
    .ale_o      (seq_ale_w),
    .wr_n_o     (seq_wr_n_w),
    .rd_n_o     (seq_rd_n_w),
    .rdata_o    (seq_rdata_w)
  );

  // Strobe pins share the pad stage timing and go idle with reset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ale_o  <= 1'b0;
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
    end else begin
      ale_o  <= seq_ale_w && ext_en_r;
      wr_n_o <= seq_wr_n_w || !ext_en_r;
      rd_n_o <= seq_rd_n_w || !ext_en_r;
    end
  end

  // ========================================================================
  // Ports: A carries address/data and C high address while memory is enabled.
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      ovr_en_w[b]  = 1'b0;
      ovr_out_w[b] = '0;
      ovr_oe_w[b]  = '0;
    end
    ovr_en_w[BANK_A]  = ext_en_r;
    ovr_out_w[BANK_A] = seq_ad_out_w;
    ovr_oe_w[BANK_A]  = {PORT_W{seq_ad_oe_w}};
    ovr_en_w[BANK_C]  = ext_en_r;
    ovr_out_w[BANK_C] = ext_addr_r[EXT_ADDR_W-1:PORT_W];
    ovr_oe_w[BANK_C]  = '1;
  end

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    gpio_bank #(.WIDTH(PORT_W)) u_bank (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .wr_out_i  (wr_out_w[g]),
      .wr_dir_i  (wr_dir_w[g]),
      .wdata_i   (dat_i[PORT_W-1:0]),
      .ovr_en_i  (ovr_en_w[g]),
      .ovr_out_i (ovr_out_w[g]),
      .ovr_oe_i  (ovr_oe_w[g]),
      .latch_o   (latch_w[g]),
      .dir_o     (dir_w[g]),
      .pad_out_o (pad_out_w[g]),
      .pad_oe_o  (pad_oe_w[g]),
      .pad_pu_o  (pad_pu_w[g])
    );
  end

  assign bank_a_lines_o    = pad_out_w[BANK_A];
  assign bank_a_lines_oe_o = pad_oe_w[BANK_A];
  assign bank_a_lines_pu_o = pad_pu_w[BANK_A];
  assign bank_b_lines_o    = pad_out_w[BANK_B];
  assign bank_b_lines_oe_o = pad_oe_w[BANK_B];
  assign bank_b_lines_pu_o = pad_pu_w[BANK_B];
  assign bank_c_lines_o    = pad_out_w[BANK_C];
  assign bank_c_lines_oe_o = pad_oe_w[BANK_C];
  assign bank_c_lines_pu_o = pad_pu_w[BANK_C];
  assign bank_d_lines_o    = pad_out_w[BANK_D];
  assign bank_d_lines_oe_o = pad_oe_w[BANK_D];
  assign bank_d_lines_pu_o = pad_pu_w[BANK_D];

  // ========================================================================
  // Checks.
  int unsigned low_cnt_r;

  // Counts clock edges with reset held low, for the least-pulse check.
  always_ff @(posedge clk_i) begin
    low_cnt_r <= reset_n_i ? 0 : low_cnt_r + 1;
  end

  float_on_reset_a: assert property (@(posedge clk_i) !reset_n_i |-> ##0
    (bank_a_lines_oe_o == '0 && bank_b_lines_oe_o == '0 && bank_c_lines_oe_o == '0 && bank_d_lines_oe_o == '0))
    else $error("port lines driven during reset");

  reset_hold_a: assert property (@(posedge clk_i) (low_cnt_r >= RESET_MIN_CYC) |->
    (!ack_o && !ale_o && bank_b_lines_pu_o == '0))
    else $error("block not reset after long low pulse");

  pull_enable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $past(reset_n_i) |-> bank_b_lines_pu_o == $past(~dir_w[BANK_B] & latch_w[BANK_B]))
    else $error("pull-up enable wrong");

  drive_dir_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $past(reset_n_i) |-> (bank_d_lines_oe_o == $past(dir_w[BANK_D]) &&
                          bank_d_lines_o == $past(latch_w[BANK_D])))
    else $error("line direction or value wrong");

  high_addr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ext_en_r && $stable(ext_en_r) && $stable(ext_addr_r) |=>
      (bank_c_lines_oe_o == '1 && bank_c_lines_o == $past(ext_addr_r[EXT_ADDR_W-1:PORT_W])))
    else $error("third port not driving high address");

  sequence addr_phase_s;
    ale_o && bank_a_lines_oe_o == '1 && bank_a_lines_o == $past(ext_addr_r[PORT_W-1:0], 2);
  endsequence
  sequence wr_phase_s;
    !ale_o && !wr_n_o && bank_a_lines_oe_o == '1 && bank_a_lines_o == $past(ext_wdata_r, 3);
  endsequence
  sequence rd_phase_s;
    !ale_o && !rd_n_o && bank_a_lines_oe_o == '0;
  endsequence

  ale_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start_wr_w ##1 ext_en_r[*2] |-> addr_phase_s ##1 wr_phase_s ##1 (wr_n_o && !ale_o))
    else $error("write access phases wrong");

  ale_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start_rd_w ##1 ext_en_r[*2] |-> addr_phase_s ##1 rd_phase_s ##1 rd_n_o)
    else $error("read access phases wrong");

  latch_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_req_w && sel_i[0] && idx_w == BANK_B_OUT_IDX |=> latch_w[BANK_B] == $past(dat_i[PORT_W-1:0]))
    else $error("output latch write lost");

  pin_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_w && !we_i && idx_w == BANK_C_PIN_IDX |=> ack_o ##0 dat_o == {24'h000000, $past(bank_c_lines_i)})
    else $error("pin sense read wrong");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_w |=> ack_o ##1 !ack_o)
    else $error("bus ack not one cycle");

endmodule // parallel_io_ports
`default_nettype wire

// ==== verif/pin_world_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// One port's pads with their outside load: drive, else pull-up, else load.
module pad_load_model (
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] load_i,
  output logic      [7:0] lvl_o
);
  // A pulled-up input only reads low if the load is strong, so the pull-up wins here.
  assign lvl_o = (oe_i & out_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & load_i);
endmodule // pad_load_model

// ==========================================================================
// Outside address latch on the multiplexed lines.
module addr_latch_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] ad_i,
  output logic      [7:0] lo_addr_o
);
  // Captures the low address at the edge that ends the strobe cycle.
  always_ff @(posedge clk_i) begin
    if (ale_i) begin
      lo_addr_o <= ad_i;
    end
  end
endmodule // addr_latch_model
`default_nettype wire

// ==== verif/parallel_io_ports_abc_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the four-port block.
module parallel_io_ports_abc_tb_top
  import gpio_pkg::*;
;
  logic        clk_i, reset_n_i, cyc, stb, we, ack, ale, wr_n, rd_n;
  logic [7:0]  adr, load_a, load_b, latched;
  logic [31:0] dat_w, dat_r, q;
  logic [7:0]  a_o, a_oe, a_pu, a_lv, b_o, b_oe, b_pu, b_lv, c_o, c_oe, c_pu, c_lv, d_o, d_oe, d_pu, d_lv;
  logic [21:0] rows [13];
  int          err_total, samples_checked, n;

  parallel_io_ports dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .ale_o(ale), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .bank_a_lines_i(a_lv), .bank_a_lines_o(a_o), .bank_a_lines_oe_o(a_oe), .bank_a_lines_pu_o(a_pu),
    .bank_b_lines_i(b_lv), .bank_b_lines_o(b_o), .bank_b_lines_oe_o(b_oe), .bank_b_lines_pu_o(b_pu),
    .bank_c_lines_i(c_lv), .bank_c_lines_o(c_o), .bank_c_lines_oe_o(c_oe), .bank_c_lines_pu_o(c_pu),
    .bank_d_lines_i(d_lv), .bank_d_lines_o(d_o), .bank_d_lines_oe_o(d_oe), .bank_d_lines_pu_o(d_pu));
  pad_load_model pa_u (.oe_i(a_oe), .out_i(a_o), .pu_i(a_pu), .load_i(load_a), .lvl_o(a_lv));
  pad_load_model pb_u (.oe_i(b_oe), .out_i(b_o), .pu_i(b_pu), .load_i(load_b), .lvl_o(b_lv));
  pad_load_model pc_u (.oe_i(c_oe), .out_i(c_o), .pu_i(c_pu), .load_i(8'h00), .lvl_o(c_lv));
  pad_load_model pd_u (.oe_i(d_oe), .out_i(d_o), .pu_i(d_pu), .load_i(8'h00), .lvl_o(d_lv));
  addr_latch_model al_u (.clk_i(clk_i), .ale_i(ale), .ad_i(a_lv), .lo_addr_o(latched));

  // ========================================================================
  // Clock, comparison, bus cycle and closing report.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic cycle: held until ack is sampled, read data taken at that edge.
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
  endtask

  // Polls the busy flag until the external access is over.
  task automatic wait_idle;
    for (int k = 0; k < 10; k++) begin
      wb(1'b0, EXT_CTRL_IDX, 32'h00000000);
      if (q[1] === 1'b0) break;
    end
    chk("busy", q[1], 32'h0);
  endtask

  // ========================================================================
  // Table of register rows {index, write, readback}, then hand-written cases.
  initial begin
    reset_n_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h00000000;
    load_a = 8'h00;
    load_b = 8'hFF;
    rows = '{{6'h1A, 8'hF0, 8'hF0}, {6'h1B, 8'hA5, 8'hA5}, {6'h17, 8'h3C, 8'h3C}, {6'h18, 8'h5A, 8'h5A},
             {6'h14, 8'h0F, 8'h0F}, {6'h15, 8'h81, 8'h81}, {6'h11, 8'hC3, 8'hC3}, {6'h12, 8'h66, 8'h66},
             {6'h3F, 8'h55, 8'h00}, {6'h19, 8'hFF, 8'hA5}, {6'h16, 8'hFF, 8'hDB}, {6'h13, 8'hFF, 8'h81},
             {6'h10, 8'hFF, 8'h66}};
    // A real falling edge clears the pads before the first clock edge.
    #1 reset_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b1, rows[i][21:16], {24'hABCDEF, rows[i][15:8]});
      wb(1'b0, rows[i][21:16], 32'h00000000);
      chk("readback", q, {24'h000000, rows[i][7:0]});
    end
    @(negedge clk_i);
    chk("a pads", {a_oe, a_o, a_pu}, 32'h00F0A505);
    chk("b pads", {b_oe, b_o, b_pu}, 32'h003C5A42);
    chk("c pads", {c_oe, c_o, c_pu}, 32'h000F8180);
    chk("d pads", {d_oe, d_o, d_pu}, 32'h00C36624);
    // External write, then read: third port carries the high address.
    wb(1'b1, EXT_ADDR_IDX, 32'h000012C4);
    wb(1'b1, EXT_DATA_IDX, 32'h00000077);
    wb(1'b1, EXT_CTRL_IDX, 32'h00000001);
    @(negedge clk_i);
    chk("c ext", {c_oe, c_o}, 32'h0000FF12);
    wb(1'b1, EXT_CMD_IDX, 32'h00000002);
    for (int k = 0; k < 10 && wr_n !== 1'b0; k++) @(negedge clk_i);
    chk("ad data", {wr_n, a_oe, a_o}, 32'h0000FF77);
    chk("latched", latched, 32'h000000C4);
    wait_idle();
    load_a <= 8'h3F;
    wb(1'b1, EXT_CMD_IDX, 32'h00000001);
    for (int k = 0; k < 10 && rd_n !== 1'b0; k++) @(negedge clk_i);
    chk("rd strobe", {rd_n, ale, a_oe}, 32'h00000000);
    wait_idle();
    wb(1'b0, EXT_DATA_IDX, 32'h00000000);
    chk("ext read", q, 32'h0000003F);
    // Reset between edges must float every line before any clock edge.
    @(posedge clk_i);
    #7 reset_n_i = 1'b0;
    #2;
    chk("oe in reset", {a_oe, b_oe, c_oe, d_oe}, 32'h00000000);
    chk("pu in reset", {a_pu, b_pu, c_pu, d_pu}, 32'h00000000);
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wb(1'b0, BANK_A_DIR_IDX, 32'h00000000);
    chk("dir reset", q, 32'h00000000);
    wrap_up();
  end
endmodule // parallel_io_ports_abc_tb_top
`default_nettype wire
